// ---- hdl/monitor_config_offset_regs.sv ----
// APB register bank for the remote sensor 2 offset and configuration register 2.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module monitor_config_offset_regs
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Remote sensor 2 raw reading from the converter
  input  wire logic        remote2_raw_valid,
  input  wire logic [7:0]  remote2_raw,
  // Corrected reading and limit flags
  output var  logic [7:0]  remote2_temp,
  output var  logic        remote2_temp_valid,
  output var  logic        remote2_over,
  output var  logic        remote2_under,
  // Converter and fan input control
  output var  monitor_cfg_pkg::converter_ctrl_t converter_ctrl
);

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    sel_none, sel_offset, sel_cfg2, sel_cfg4, sel_test2, sel_fan1,
    sel_lock, sel_status, sel_limits
  } reg_sel_t;

  // Byte address is four times the printed index; anything else is unmapped.
  function automatic reg_sel_t decode(input logic [11:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    if (addr[1:0] != 2'b00 || addr[11:10] != 2'b00)
      decode = sel_none;
    else if (idx == monitor_cfg_pkg::reg_index_remote2_offset)
      decode = sel_offset;
    else if (idx == monitor_cfg_pkg::reg_index_monitor_config_two)
      decode = sel_cfg2;
    else if (idx == monitor_cfg_pkg::reg_index_monitor_config_four)
      decode = sel_cfg4;
    else if (idx == monitor_cfg_pkg::reg_index_test_two)
      decode = sel_test2;
    else if (idx == monitor_cfg_pkg::reg_index_fan1_min_high)
      decode = sel_fan1;
    else if (idx == monitor_cfg_pkg::reg_index_lock_ctrl)
      decode = sel_lock;
    else if (idx == monitor_cfg_pkg::reg_index_temp_status)
      decode = sel_status;
    else if (idx == monitor_cfg_pkg::reg_index_remote2_limits)
      decode = sel_limits;
    else
      decode = sel_none;
  endfunction : decode

  reg_sel_t sel;
  logic     access;
  logic     wr;
  assign sel    = decode(paddr);
  assign access = psel && penable && !pready;
  assign wr     = access && pwrite;

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic                                 lock;
  logic [7:0]                           remote2_offset;
  monitor_cfg_pkg::monitor_config_two_t config_two;
  logic [7:0]                           config_four;
  logic [7:0]                           test_two;
  logic [7:0]                           fan1_min_high;
  logic [7:0]                           high_limit;
  logic [7:0]                           low_limit;

  // The lock is sticky until reset, so locked settings survive runaway software.
  always_ff @(posedge clock)
  begin
    if (reset)
      lock <= 1'b0;
    else if (wr && sel == sel_lock && pwdata[0])
      lock <= 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      remote2_offset <= monitor_cfg_pkg::remote2_offset_reset;
    else if (wr && sel == sel_offset && !lock)
      remote2_offset <= pwdata[7:0];
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      config_two <= monitor_cfg_pkg::monitor_config_two_reset[6:0];
    else if (wr && sel == sel_cfg2 && !lock)
      config_two <= pwdata[6:0];
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      config_four   <= monitor_cfg_pkg::config_four_reset;
      test_two      <= monitor_cfg_pkg::test_two_reset;
      fan1_min_high <= monitor_cfg_pkg::fan1_min_high_reset;
      high_limit    <= monitor_cfg_pkg::high_limit_reset;
      low_limit     <= monitor_cfg_pkg::low_limit_reset;
    end
    else if (wr)
    begin
      if (sel == sel_cfg4)
        config_four <= pwdata[7:0];
      else if (sel == sel_test2)
        test_two <= pwdata[7:0];
      else if (sel == sel_fan1)
        fan1_min_high <= pwdata[7:0];
      else if (sel == sel_limits)
      begin
        high_limit <= pwdata[7:0];
        low_limit  <= pwdata[15:8];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // APB answer
  // ---------------------------------------------------------------------------
  // One wait state: pready rises in the access phase's second cycle.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= access;
      pslverr <= access && sel == sel_none;
      prdata  <= 32'h0000_0000;
      if (access && !pwrite)
      begin
        case (sel)
          sel_offset: prdata <= {24'h00_0000, remote2_offset};
          sel_cfg2:   prdata <= {25'h000_0000, config_two};
          sel_cfg4:   prdata <= {24'h00_0000, config_four};
          sel_test2:  prdata <= {24'h00_0000, test_two};
          sel_fan1:   prdata <= {24'h00_0000, fan1_min_high};
          sel_lock:   prdata <= {31'h0000_0000, lock};
          sel_status: prdata <= {22'h00_0000, remote2_over, remote2_under, remote2_temp};
          sel_limits: prdata <= {16'h0000, low_limit, high_limit};
          default:    prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Converter control
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (reset)
      converter_ctrl <= '0;
    else
    begin
      converter_ctrl.two_wire_sel           <= config_two.two_wire_sel;
      converter_ctrl.two_wire_threshold     <= (|config_two.two_wire_sel)
                                               ? config_four : 8'h00;
      converter_ctrl.averaging_disable      <= config_two.averaging_disable;
      converter_ctrl.input_divider_bypass   <= config_two.input_divider_bypass;
      converter_ctrl.single_channel_convert <= config_two.single_channel_convert;
      converter_ctrl.external_trigger_enable <= config_two.single_channel_convert
        && test_two[monitor_cfg_pkg::ext_trigger_pos];
      converter_ctrl.channel_select         <= config_two.single_channel_convert
        ? fan1_min_high[monitor_cfg_pkg::chan_sel_lsb +: 3] : 3'h0;
    end
  end

  // ---------------------------------------------------------------------------
  // Offset correction and limit check
  // ---------------------------------------------------------------------------
  logic       corr_valid;
  logic [7:0] corr_value;

  offset_adder #(.width(8)) u_offset_adder
  (
    .clock           (clock),
    .reset           (reset),
    .raw_valid       (remote2_raw_valid),
    .raw_value       (remote2_raw),
    .offset          (remote2_offset),
    .corrected_valid (corr_valid),
    .corrected_value (corr_value)
  );

  // Only the corrected value is stored and compared, never the raw one.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      remote2_temp       <= 8'h00;
      remote2_temp_valid <= 1'b0;
      remote2_over       <= 1'b0;
      remote2_under      <= 1'b0;
    end
    else
    begin
      remote2_temp_valid <= corr_valid;
      if (corr_valid)
      begin
        remote2_temp  <= corr_value;
        remote2_over  <= $signed(corr_value) > $signed(high_limit);
        remote2_under <= $signed(corr_value) < $signed(low_limit);
      end
    end
  end

endmodule : monitor_config_offset_regs
`default_nettype wire

// ---- hdl/monitor_cfg_pkg.sv ----
// Constants, field layout and carrier types of the monitor configuration and offset registers.
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package monitor_cfg_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] reg_index_fan1_min_high      = 8'h55;
  localparam logic [7:0] reg_index_remote2_offset     = 8'h72;
  localparam logic [7:0] reg_index_monitor_config_two = 8'h73;
  localparam logic [7:0] reg_index_monitor_config_four = 8'h7d;
  localparam logic [7:0] reg_index_test_two           = 8'h7f;
  localparam logic [7:0] reg_index_lock_ctrl          = 8'h80;
  localparam logic [7:0] reg_index_temp_status        = 8'h81;
  localparam logic [7:0] reg_index_remote2_limits     = 8'h82;

  // ---------------------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------------------
  localparam logic [7:0] remote2_offset_reset     = 8'h00;
  localparam logic [7:0] monitor_config_two_reset = 8'h00;
  localparam logic [7:0] config_four_reset        = 8'h00;
  localparam logic [7:0] test_two_reset           = 8'h00;
  localparam logic [7:0] fan1_min_high_reset      = 8'h00;
  localparam logic [7:0] high_limit_reset         = 8'h7f;
  localparam logic [7:0] low_limit_reset          = 8'h80;
  localparam int         avg_disable_pos          = 4;
  localparam int         divider_bypass_pos       = 5;
  localparam int         single_single_channel_convert_pos          = 6;
  localparam int         ext_trigger_pos          = 2;
  localparam int         chan_sel_lsb             = 5;

  // ---------------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic       single_channel_convert;
    logic       input_divider_bypass;
    logic       averaging_disable;
    logic [3:0] two_wire_sel;
  } monitor_config_two_t;

  typedef struct packed {
    logic [3:0] two_wire_sel;
    logic [7:0] two_wire_threshold;
    logic       averaging_disable;
    logic       input_divider_bypass;
    logic       single_channel_convert;
    logic       external_trigger_enable;
    logic [2:0] channel_select;
  } converter_ctrl_t;

endpackage : monitor_cfg_pkg

// ---- hdl/offset_adder.sv ----
// Signed offset correction for one temperature reading.
`timescale 1ns/1ps
`default_nettype none
module offset_adder
#(
  parameter int width = 8
)
(
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // Raw reading in, corrected reading out
  input  wire logic             raw_valid,
  input  wire logic [width-1:0] raw_value,
  input  wire logic [7:0]       offset,
  output var  logic             corrected_valid,
  output var  logic [width-1:0] corrected_value
);

  // ---------------------------------------------------------------------------
  // Saturating signed add
  // ---------------------------------------------------------------------------
  // Saturation keeps a large negative offset from wrapping a cold reading hot.
  logic signed [width:0] sum;
  assign sum = $signed({raw_value[width-1], raw_value})
             + $signed({{(width-7){offset[7]}}, offset});

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      corrected_valid <= 1'b0;
      corrected_value <= '0;
    end
    else
    begin
      corrected_valid <= raw_valid;
      if (raw_valid)
      begin
        if (sum[width] != sum[width-1])
          corrected_value <= sum[width] ? {1'b1, {(width-1){1'b0}}}
                                        : {1'b0, {(width-1){1'b1}}};
        else
          corrected_value <= sum[width-1:0];
      end
    end
  end

endmodule : offset_adder
`default_nettype wire

// ---- sim/monitor_regs_props.sv ----
// Port checker for the monitor configuration and offset register bank.
`timescale 1ns/1ps
`default_nettype none
module monitor_regs_props
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset,
  // APB slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Temperature path
  input wire logic        remote2_raw_valid,
  input wire logic [7:0]  remote2_raw,
  input wire logic [7:0]  remote2_temp,
  input wire logic        remote2_temp_valid,
  input wire logic        remote2_over,
  input wire logic        remote2_under,
  // Converter control
  input wire monitor_cfg_pkg::converter_ctrl_t converter_ctrl
);
  //----------------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after access");
  a_ready_pulse_only: assert property (pready |-> $past(psel && penable) ##1 !pready)
    else $error("pready not a single pulse");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata nonzero outside answer");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_temp_valid_delay: assert property (remote2_raw_valid |-> ##2 remote2_temp_valid)
    else $error("corrected reading late");
  a_temp_valid_cause: assert property (remote2_temp_valid |-> $past(remote2_raw_valid, 2))
    else $error("corrected reading without sample");
  a_temp_holds_value: assert property (!remote2_temp_valid |-> $stable(remote2_temp))
    else $error("reading changed without valid");
  a_threshold_gate: assert property (converter_ctrl.two_wire_sel == 4'h0 |->
    converter_ctrl.two_wire_threshold == 8'h00)
    else $error("threshold without two wire input");
  a_single_gate: assert property (!converter_ctrl.single_channel_convert |->
    !converter_ctrl.external_trigger_enable && converter_ctrl.channel_select == 3'h0)
    else $error("trigger or channel outside single mode");
endmodule : monitor_regs_props
bind monitor_config_offset_regs monitor_regs_props monitor_regs_props_i (.clock(clock),
  .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .remote2_raw_valid(remote2_raw_valid), .remote2_raw(remote2_raw),
  .remote2_temp(remote2_temp), .remote2_temp_valid(remote2_temp_valid),
  .remote2_over(remote2_over), .remote2_under(remote2_under),
  .converter_ctrl(converter_ctrl));
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking testbench of the monitor configuration and offset register bank.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  //----------------------------------------------------------------------------
  // Signals and design
  //----------------------------------------------------------------------------
  logic        clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, raw_valid = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, temp_valid, over, under, e;
  logic [7:0]  raw = 8'h00, temp, off, cfg, c4, t2, f1, hi, lo, ex;
  monitor_cfg_pkg::converter_ctrl_t ctrl;
  int          failures = 0, compares = 0, cycles = 0;
  monitor_config_offset_regs monitor_config_offset_regs_i (.clock(clock), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .remote2_raw_valid(raw_valid),
    .remote2_raw(raw), .remote2_temp(temp), .remote2_temp_valid(temp_valid),
    .remote2_over(over), .remote2_under(under), .converter_ctrl(ctrl));
  initial forever #5 clock = ~clock;
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      end_sim();
    end
  end
  //----------------------------------------------------------------------------
  // Tasks and expectations
  //----------------------------------------------------------------------------
  task end_sim();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task chk(string n, logic [31:0] s, logic [31:0] x);
    compares++;
    if (s !== x)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  // The wait loop samples pready before the edge updates it, as an APB master must.
  task apb(logic w, logic [7:0] i, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= {2'b00, i, 2'b00}; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1'b1 && ++n < 50);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task rd(logic [7:0] i, logic [31:0] x);
    apb(0, i, 32'h0);
    chk("read", q, x);
  endtask : rd
  function logic [7:0] sat(logic [7:0] a, logic [7:0] b);
    logic [8:0] s;
    s = {a[7], a} + {b[7], b};
    if (s[8] != s[7])
      return s[8] ? 8'h80 : 8'h7f;
    return s[7:0];
  endfunction : sat
  function monitor_cfg_pkg::converter_ctrl_t expc();
    expc.two_wire_sel = cfg[3:0];
    expc.two_wire_threshold = (cfg[3:0] != 4'h0) ? c4 : 8'h00;
    expc.averaging_disable = cfg[4];
    expc.input_divider_bypass = cfg[5];
    expc.single_channel_convert = cfg[6];
    expc.external_trigger_enable = cfg[6] & t2[2];
    expc.channel_select = cfg[6] ? f1[7:5] : 3'h0;
  endfunction : expc
  task temp_case(logic [7:0] r);
    int n;
    n = 0;
    @(posedge clock);
    raw_valid <= 1;
    raw <= r;
    @(posedge clock);
    raw_valid <= 0;
    do @(posedge clock); while (temp_valid !== 1'b1 && ++n < 10);
    ex = sat(r, off);
    chk("temp", temp, ex);
    chk("over", over, 32'($signed(ex) > $signed(hi)));
    chk("under", under, 32'($signed(ex) < $signed(lo)));
  endtask : temp_case
  //----------------------------------------------------------------------------
  // Main sequence
  //----------------------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h18036933));
    repeat (4) @(posedge clock);
    reset <= 0;
    rd(8'h72, 32'h0);
    rd(8'h73, 32'h0);
    chk("ctrl", ctrl, 32'h0);
    hi = 8'h20;
    lo = 8'he0;
    apb(1, 8'h82, {16'h0000, lo, hi});
    rd(8'h82, {16'h0000, lo, hi});
    // First two passes hit the saturation corners and the fixed mode patterns.
    for (int k = 0; k < 12; k++)
    begin
      off = k == 0 ? 8'h80 : k == 1 ? 8'h7f : 8'($urandom);
      cfg = k == 0 ? 8'h40 : k == 1 ? 8'h0f : 8'($urandom);
      c4 = 8'($urandom);
      t2 = 8'($urandom);
      f1 = 8'($urandom);
      apb(1, 8'h72, off);
      apb(1, 8'h73, cfg);
      apb(1, 8'h7d, c4);
      apb(1, 8'h7f, t2);
      apb(1, 8'h55, f1);
      cfg[7] = 1'b0;
      rd(8'h72, off);
      rd(8'h73, cfg);
      chk("ctrl", ctrl, expc());
      temp_case(k == 0 ? 8'h80 : k == 1 ? 8'h7f : 8'($urandom));
    end
    apb(0, 8'h10, 32'h0);
    chk("unmapped error", e, 32'h1);
    chk("unmapped data", q, 32'h0);
    apb(1, 8'h80, 32'h1);
    apb(1, 8'h72, ~off);
    apb(1, 8'h73, ~cfg);
    rd(8'h72, off);
    rd(8'h73, cfg);
    chk("locked ctrl", ctrl, expc());
    temp_case(8'h10);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
